/* rtl/reset_initial_state_logic.sv */
// Reset-cause decoder, reset flags and initial state of core and peripherals
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "reset_state_params.svh"

module reset_initial_state_logic (
  input  wire logic                         ref_clk_in,
  input  wire logic                         rst_in,
  // Events from the core and the analog supply monitor
  input  wire logic                         supply_dip_reset_in,
  input  wire logic                         low_power_in,
  input  wire logic                         sleep_entry_in,
  input  wire logic                         clear_watchdog_in,
  input  wire logic                         pc_update_in,
  input  wire reset_state_pkg::byte_t       pc_value_in,
  input  wire logic                         sp_update_in,
  input  wire reset_state_pkg::byte_t       sp_value_in,
  // Register port
  input  wire reset_state_pkg::addr_t       reg_addr_in,
  input  wire reset_state_pkg::byte_t       reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  output logic [7:0]                        reg_rdata_out,
  output logic                              irq_out,
  // State presented to the core
  output logic                              timeout_flag_out,
  output logic                              powerdown_flag_out,
  output logic                              supply_dip_flag_out,
  output logic [4:0]                        reset_cause_out,
  output logic                              core_hold_out,
  output logic [7:0]                        program_counter_low_out,
  output logic [7:0]                        stack_pointer_out,
  output logic [15:0]                       watchdog_counter_out,
  output logic [15:0]                       timebase0_out,
  output logic [15:0]                       timebase1_out,
  output logic [7:0]                        int_enable_out,
  output logic [7:0]                        timer_ctrl_out,
  output logic [7:0]                        port_data_out,
  output logic [7:0]                        port_dir_out,
  output logic [7:0]                        pullup_out,
  output logic [7:0]                        wakeup_out
);
  import reset_state_pkg::*;

  localparam logic [7:0] HOLD_CYC = 8'(`RESTART_HOLD_CYC);

  // ************************************************************
  // Supply monitor synchroniser
  // ************************************************************
  logic dip_meta_reg;
  logic dip_sync_reg;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      dip_meta_reg <= 1'b0;
      dip_sync_reg <= 1'b0;
    end else begin
      dip_meta_reg <= supply_dip_reset_in;
      dip_sync_reg <= dip_meta_reg;
    end
  end

  // ************************************************************
  // Watchdog and time base counters
  // ************************************************************
  logic [15:0] wdt_reg;
  logic [15:0] wdt_next;
  logic [15:0] tb0_reg;
  logic [15:0] tb0_next;
  logic [15:0] tb1_reg;
  logic [15:0] tb1_next;
  logic        wdt_hit;
  logic        full_reset;
  logic        any_reset;

  always_comb begin
    wdt_hit  = (wdt_reg == `WDT_PERIOD - 16'h0001);
    wdt_next = wdt_reg + 16'h0001;
    if (any_reset || clear_watchdog_in || sleep_entry_in || wdt_hit) begin
      wdt_next = 16'h0000;
    end
    tb0_next = (tb0_reg == `TIMEBASE0_PERIOD - 16'h0001) ? 16'h0000 : tb0_reg + 16'h0001;
    tb1_next = (tb1_reg == `TIMEBASE1_PERIOD - 16'h0001) ? 16'h0000 : tb1_reg + 16'h0001;
    if (full_reset) begin
      tb0_next = 16'h0000;
      tb1_next = 16'h0000;
    end
  end

  // Counting resumes on the first edge after release
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wdt_reg <= 16'h0000; // see R7
      tb0_reg <= 16'h0000; // see R7
      tb1_reg <= 16'h0000; // see R7
    end else begin
      wdt_reg <= wdt_next;
      tb0_reg <= tb0_next;
      tb1_reg <= tb1_next;
    end
  end

  // ************************************************************
  // Reset cause decoder
  // ************************************************************
  reset_cause_e apply_reg;
  reset_cause_e apply_next;
  reset_cause_e cause_reg;
  reset_cause_e cause_next;
  logic [7:0]   hold_reg;
  logic [7:0]   hold_next;

  // Supply monitor is off in idle and sleep, so its input is ignored there
  always_comb begin
    apply_next = CAUSE_NONE;
    if (dip_sync_reg && !low_power_in) begin
      apply_next = CAUSE_DIP; // see R15
    end else if (wdt_hit) begin
      apply_next = low_power_in ? CAUSE_WDT_IDLE : CAUSE_WDT_ACT;
    end
    cause_next = cause_reg;
    if (apply_reg != CAUSE_NONE) begin
      cause_next = apply_reg;
    end
    hold_next = (hold_reg != 8'h00) ? hold_reg - 8'h01 : 8'h00;
    if (any_reset) begin
      hold_next = HOLD_CYC;
    end
  end

  // Power-on is rst_in itself, so it overrides every other source
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      apply_reg <= CAUSE_NONE; // see R15
      cause_reg <= CAUSE_POWER_ON;
      hold_reg  <= HOLD_CYC;
    end else begin
      apply_reg <= apply_next;
      cause_reg <= cause_next;
      hold_reg  <= hold_next;
    end
  end

  always_comb begin
    full_reset = (apply_reg == CAUSE_DIP) || (apply_reg == CAUSE_WDT_ACT);
    any_reset  = full_reset || (apply_reg == CAUSE_WDT_IDLE);
  end

  // ************************************************************
  // Reset flags
  // ************************************************************
  logic timeout_reg;
  logic timeout_next;
  logic powerdown_reg;
  logic powerdown_next;
  logic dip_flag_reg;
  logic dip_flag_next;
  logic wr_flag;

  always_comb begin
    wr_flag        = reg_wr_in && (reg_addr_in == `OFS_RESET_FLAG);
    timeout_next   = timeout_reg;
    powerdown_next = powerdown_reg;
    if (clear_watchdog_in) begin
      timeout_next   = 1'b0; // see R1
      powerdown_next = 1'b0;
    end
    if (sleep_entry_in) begin
      timeout_next   = 1'b0; // see R1
      powerdown_next = 1'b1;
    end
    case (apply_reg)
      CAUSE_WDT_ACT: begin
        timeout_next = 1'b1; // see R4
      end
      CAUSE_WDT_IDLE: begin
        timeout_next   = 1'b1; // see R5
        powerdown_next = 1'b1;
      end
      default: begin
        // A supply dip leaves both flags as they are, see R3
      end
    endcase
    dip_flag_next = dip_flag_reg;
    if (wr_flag && !reg_wdata_in[`BIT_DIP_FLAG]) begin
      dip_flag_next = 1'b0; // see R14
    end
    if (apply_reg == CAUSE_DIP) begin
      dip_flag_next = 1'b1; // see R14
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      timeout_reg   <= 1'b0; // see R2
      powerdown_reg <= 1'b0; // see R2
      dip_flag_reg  <= 1'b0;
    end else begin
      timeout_reg   <= timeout_next;
      powerdown_reg <= powerdown_next;
      dip_flag_reg  <= dip_flag_next;
    end
  end

  // ************************************************************
  // Program counter low byte and stack pointer
  // ************************************************************
  byte_t pcl_reg;
  byte_t pcl_next;
  byte_t sp_reg;
  byte_t sp_next;

  // Every reset type restarts execution, including the idle wake
  always_comb begin
    pcl_next = pc_update_in ? pc_value_in : pcl_reg;
    sp_next  = sp_update_in ? sp_value_in : sp_reg;
    if (any_reset) begin
      pcl_next = `PC_LOW_RESET; // see R11
      sp_next  = `STACK_TOP; // see R13
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pcl_reg <= `PC_LOW_RESET; // see R10
      sp_reg  <= `STACK_TOP; // see R10
    end else begin
      pcl_reg <= pcl_next;
      sp_reg  <= sp_next;
    end
  end

  // ************************************************************
  // Banked peripheral and core registers
  // ************************************************************
  byte_t bank_value [`BANK_COUNT];
  localparam logic [79:0] BANK_POR  = `BANK_POR_VALS;
  localparam logic [9:0]  BANK_KEEP = `BANK_KEEP_ACT;

  // Idle wake leaves the bank alone, see R13
  for (genvar g = 0; g < `BANK_COUNT; g++) begin : g_bank
    reset_bank_reg #(
      .POR_VAL  (BANK_POR[8*g +: 8]),
      .KEEP_ACT (BANK_KEEP[g])
    ) u_reg (
      .ref_clk_in    (ref_clk_in),
      .rst_in        (rst_in), // see R6 R8 R9 R12
      .full_reset_in (full_reset), // see R9 R11 R12
      .wr_en_in      (reg_wr_in && (reg_addr_in == `OFS_FIRST_BANK + 4'(g))),
      .wr_data_in    (reg_wdata_in),
      .value_out     (bank_value[g])
    );
  end

  // ************************************************************
  // Event interrupts
  // ************************************************************
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_stat_next;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_mask_next;
  logic       irq_reg;
  logic       irq_next;
  logic [2:0] irq_set;

  // Set beats a same-cycle write-one clear
  always_comb begin
    irq_set                  = 3'h0;
    irq_set[`IRQ_WDT_ACTIVE] = (apply_reg == CAUSE_WDT_ACT);
    irq_set[`IRQ_WDT_IDLE]   = (apply_reg == CAUSE_WDT_IDLE);
    irq_set[`IRQ_SUPPLY_DIP] = (apply_reg == CAUSE_DIP);
    irq_stat_next = irq_stat_reg;
    if (reg_wr_in && (reg_addr_in == `OFS_IRQ_STATUS)) begin
      irq_stat_next = irq_stat_reg & ~reg_wdata_in[2:0];
    end
    irq_stat_next = irq_stat_next | irq_set;
    irq_mask_next = irq_mask_reg;
    if (reg_wr_in && (reg_addr_in == `OFS_IRQ_MASK)) begin
      irq_mask_next = reg_wdata_in[2:0];
    end
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg      <= irq_next;
    end
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  byte_t rdata_reg;
  byte_t rdata_next;

  // Read data are valid only in the cycle after the strobe
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `OFS_STATUS: begin
          rdata_next[`BIT_TIMEOUT]   = timeout_reg; // see R1
          rdata_next[`BIT_POWERDOWN] = powerdown_reg;
        end
        `OFS_RESET_FLAG: begin
          rdata_next[`BIT_DIP_FLAG] = dip_flag_reg;
        end
        `OFS_IRQ_STATUS: begin
          rdata_next[2:0] = irq_stat_reg;
        end
        `OFS_IRQ_MASK: begin
          rdata_next[2:0] = irq_mask_reg;
        end
        `OFS_PC_LOW: begin
          rdata_next = pcl_reg;
        end
        `OFS_STACK_PTR: begin
          rdata_next = sp_reg;
        end
        default: begin
          rdata_next = bank_value[reg_addr_in - `OFS_FIRST_BANK];
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata_out           = rdata_reg;
  assign irq_out                 = irq_reg;
  assign timeout_flag_out        = timeout_reg;
  assign powerdown_flag_out      = powerdown_reg;
  assign supply_dip_flag_out     = dip_flag_reg;
  assign reset_cause_out         = cause_reg;
  assign core_hold_out           = (hold_reg != 8'h00) ? 1'b1 : 1'b0;
  assign program_counter_low_out = pcl_reg;
  assign stack_pointer_out       = sp_reg;
  assign watchdog_counter_out    = wdt_reg;
  assign timebase0_out           = tb0_reg;
  assign timebase1_out           = tb1_reg;
  assign int_enable_out          = bank_value[0];
  assign timer_ctrl_out          = bank_value[1];
  assign port_data_out           = bank_value[2];
  assign port_dir_out            = bank_value[3];
  assign pullup_out              = bank_value[4];
  assign wakeup_out              = bank_value[5];

endmodule : reset_initial_state_logic

`default_nettype wire

/* rtl/reset_state_params.svh */
// Constants of the reset-condition block: offsets, fields, reset values, counts
// Operation
// R1 - Status register holds timeout and powerdown flags recording the last reset source.
// R2 - Power-on reset clears both timeout and powerdown flags.
// R3 - Supply-dip reset in active mode leaves both flags unchanged.
// R4 - Active-mode watchdog reset sets timeout flag, keeps powerdown flag.
// R5 - Idle or sleep watchdog reset sets both flags, keeps other status bits.
// R6 - Power-on reset disables all interrupt enables.
// R7 - Power-on reset clears watchdog and time base counters; watchdog then counts.
// R8 - Power-on reset clears timer control registers, switching timers off.
// R9 - Power-on and active watchdog reset: port data/direction ones, pull-ups/wake-ups zero.
// R10 - Power-on reset zeroes program counter and points stack pointer at top.
// R11 - Each register has per-reset-type values; program counter low cleared always.
// R12 - Accumulator and table registers undefined at power-on, kept across watchdog resets.
// R13 - Idle or sleep watchdog reset restarts only program counter and stack pointer.
// R14 - Genuine supply-dip reset sets its flag; only a software write clears it. The code also clears it on power-on reset (rst_in).
// R15 - One decoder combines reset sources; power-on wins over all others.
`ifndef RESET_STATE_PARAMS_SVH
`define RESET_STATE_PARAMS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define OFS_STATUS      4'h0
`define OFS_RESET_FLAG  4'h1
`define OFS_IRQ_STATUS  4'h2
`define OFS_IRQ_MASK    4'h3
`define OFS_FIRST_BANK  4'h4
`define OFS_PC_LOW      4'he
`define OFS_STACK_PTR   4'hf

// ************************************************************
// Field positions
// ************************************************************
`define BIT_TIMEOUT     5
`define BIT_POWERDOWN   4
`define BIT_DIP_FLAG    2
`define IRQ_WDT_ACTIVE  0
`define IRQ_WDT_IDLE    1
`define IRQ_SUPPLY_DIP  2

// ************************************************************
// Reset values of the banked registers, index 0 in the low byte
// int_en, timer_ctrl, port_data, port_dir, pullup, wakeup, acc, table_pointer_low, table_read_high_latch, table_pointer_high
// ************************************************************
`define BANK_COUNT      10
`define BANK_POR_VALS   80'h00_00_00_00_00_00_ff_ff_00_00
`define BANK_KEEP_ACT   10'h3c0
`define STACK_TOP       8'h07
`define PC_LOW_RESET    8'h00

// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_PS     5000
`define WDT_PERIOD        16'h0100
`define TIMEBASE0_PERIOD  16'h0400
`define TIMEBASE1_PERIOD  16'h1000
`define RESTART_HOLD_NS   50
`define RESTART_HOLD_CYC  ((`RESTART_HOLD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

/* rtl/reset_state_pkg.sv */
// Types shared by the reset-condition block
package reset_state_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [3:0] addr_t;

  // Decoded reset cause, one-hot
  typedef enum logic [4:0] {
    CAUSE_NONE     = 5'b00001,
    CAUSE_POWER_ON = 5'b00010,
    CAUSE_DIP      = 5'b00100,
    CAUSE_WDT_ACT  = 5'b01000,
    CAUSE_WDT_IDLE = 5'b10000
  } reset_cause_e;

endpackage : reset_state_pkg

/* rtl/reset_bank_reg.sv */
// One byte register with a separate value for each reset type
`timescale 1ns/1ps
`default_nettype none

module reset_bank_reg #(
  parameter logic [7:0] POR_VAL  = 8'h00,
  parameter logic       KEEP_ACT = 1'b0
) (
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   full_reset_in,
  input  wire logic                   wr_en_in,
  input  wire reset_state_pkg::byte_t wr_data_in,
  output var  reset_state_pkg::byte_t value_out
);
  import reset_state_pkg::*;

  byte_t value_reg;
  byte_t value_next;

  // Idle watchdog wake never touches these; only power-on and, unless KEEP_ACT is set, full resets do
  always_comb begin
    value_next = value_reg;
    if (full_reset_in) begin
      value_next = KEEP_ACT ? value_reg : POR_VAL;
    end else if (wr_en_in) begin
      value_next = wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      value_reg <= POR_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value_out = value_reg;

endmodule : reset_bank_reg

`default_nettype wire

/* testbench/reset_initial_state_asserts.sv */
// Concurrent checks on the ports of the reset-condition block
`timescale 1ns/1ps
`default_nettype none
module reset_initial_state_asserts
  import reset_state_pkg::*;
(
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic        supply_dip_reset_in,
  input wire logic        low_power_in,
  input wire logic        sleep_entry_in,
  input wire logic        clear_watchdog_in,
  input wire addr_t       reg_addr_in,
  input wire byte_t       reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        timeout_flag_out,
  input wire logic        powerdown_flag_out,
  input wire logic        supply_dip_flag_out,
  input wire logic [4:0]  reset_cause_out,
  input wire logic [7:0]  program_counter_low_out,
  input wire logic [7:0]  stack_pointer_out,
  input wire logic [15:0] watchdog_counter_out,
  input wire logic [15:0] timebase0_out,
  input wire logic [15:0] timebase1_out,
  input wire logic [7:0]  int_enable_out,
  input wire logic [7:0]  port_data_out,
  input wire logic [7:0]  port_dir_out,
  input wire logic [7:0]  pullup_out
);
  // ************************************************************
  // Helper logic
  // ************************************************************
  // A dip takes a few cycles through the synchroniser, so keep a short history
  logic [5:0] dip_hist_reg;
  logic [5:0] dip_hist_next;
  logic       quiet;
  logic       core_restart;
  assign core_restart = program_counter_low_out == 8'h00 && stack_pointer_out == 8'h07;
  always_comb dip_hist_next = rst_in ? 6'h00 : {dip_hist_reg[4:0], supply_dip_reset_in};
  always_ff @(posedge ref_clk_in) dip_hist_reg <= dip_hist_next;
  assign quiet = !clear_watchdog_in && !sleep_entry_in && !supply_dip_reset_in
                 && dip_hist_reg == 6'h00 && !reg_wr_in;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_wrap(lp);
    watchdog_counter_out == 16'h00ff && low_power_in == lp && quiet;
  endsequence

  chk_por_flags: assert property ($fell(rst_in) |-> !timeout_flag_out && !powerdown_flag_out
    && reset_cause_out == 5'b00010) else $error("flags or cause wrong after power-on");
  chk_por_state: assert property ($fell(rst_in) |-> int_enable_out == 8'h00
    && port_data_out == 8'hff && port_dir_out == 8'hff && pullup_out == 8'h00
    && core_restart) else $error("core or port state wrong after power-on");
  chk_por_counters: assert property ($fell(rst_in) |-> watchdog_counter_out == 16'h0000
    && timebase0_out == 16'h0000 && timebase1_out == 16'h0000) else $error("counters kept");
  chk_wdt_counts: assert property (quiet |=> watchdog_counter_out ==
    (($past(watchdog_counter_out) == 16'h00ff || ($past(watchdog_counter_out, 2) == 16'h00ff
    && $past(watchdog_counter_out) == 16'h0000)) ? 16'h0000 : $past(watchdog_counter_out) + 1'b1))
    else $error("watchdog does not count");
  chk_wdt_clear: assert property (clear_watchdog_in |=> watchdog_counter_out == 16'h0000
    && !timeout_flag_out && !powerdown_flag_out) else $error("clear left state");
  chk_wdt_active: assert property (s_wrap(1'b0) |=> ##1 timeout_flag_out && core_restart
    && powerdown_flag_out == $past(powerdown_flag_out, 2) && int_enable_out == 8'h00
    && port_dir_out == 8'hff ##1 reset_cause_out == 5'b01000) else $error("active timeout");
  chk_wdt_idle: assert property (s_wrap(1'b1) |=> ##1 timeout_flag_out && powerdown_flag_out
    && core_restart && int_enable_out == $past(int_enable_out, 2)
    ##1 reset_cause_out == 5'b10000) else $error("idle timeout");
  chk_dip_keeps: assert property ($rose(supply_dip_flag_out) |->
    timeout_flag_out == $past(timeout_flag_out)
    && powerdown_flag_out == $past(powerdown_flag_out)) else $error("dip changed flags");
  chk_dip_sticky: assert property (supply_dip_flag_out && !(reg_wr_in && reg_addr_in == 4'h1
    && !reg_wdata_in[2]) |=> supply_dip_flag_out) else $error("dip flag lost");
  chk_read_status: assert property (reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out ==
    {2'b00, $past(timeout_flag_out), $past(powerdown_flag_out), 4'h0}) else $error("status read");
  chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside read");
endmodule : reset_initial_state_asserts

bind reset_initial_state_logic reset_initial_state_asserts u_chk (.ref_clk_in, .rst_in,
  .supply_dip_reset_in, .low_power_in, .sleep_entry_in, .clear_watchdog_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .timeout_flag_out,
  .powerdown_flag_out, .supply_dip_flag_out, .reset_cause_out, .program_counter_low_out,
  .stack_pointer_out, .watchdog_counter_out, .timebase0_out, .timebase1_out,
  .int_enable_out, .port_data_out, .port_dir_out, .pullup_out);
`default_nettype wire

/* testbench/reset_initial_state_logic_tb.sv */
// Self-checking bench of the reset-condition block
`timescale 1ns/1ps
`default_nettype none
module reset_initial_state_logic_tb;
  import reset_state_pkg::*;
  logic        ref_clk_in, rst_in, supply_dip_reset_in, low_power_in, sleep_entry_in;
  logic        clear_watchdog_in, pc_update_in, sp_update_in, reg_wr_in, reg_rd_in;
  byte_t       pc_value_in, sp_value_in, reg_wdata_in;
  addr_t       reg_addr_in;
  logic [7:0]  reg_rdata_out, program_counter_low_out, stack_pointer_out, int_enable_out;
  logic [7:0]  timer_ctrl_out, port_data_out, port_dir_out, pullup_out, wakeup_out;
  logic        irq_out, timeout_flag_out, powerdown_flag_out, supply_dip_flag_out, core_hold_out;
  logic [4:0]  reset_cause_out;
  logic [15:0] watchdog_counter_out, timebase0_out, timebase1_out;
  int          n_fail = 0;
  int          tests_run = 0;

  reset_initial_state_logic u_dut (.ref_clk_in, .rst_in, .supply_dip_reset_in, .low_power_in,
    .sleep_entry_in, .clear_watchdog_in, .pc_update_in, .pc_value_in, .sp_update_in,
    .sp_value_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out,
    .timeout_flag_out, .powerdown_flag_out, .supply_dip_flag_out, .reset_cause_out,
    .core_hold_out, .program_counter_low_out, .stack_pointer_out, .watchdog_counter_out,
    .timebase0_out, .timebase1_out, .int_enable_out, .timer_ctrl_out, .port_data_out,
    .port_dir_out, .pullup_out, .wakeup_out);

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : tick

  task automatic reg_write(input addr_t a, input byte_t d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input addr_t a, input byte_t exp);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk(16'(reg_rdata_out), 16'(exp));
  endtask : reg_read

  // 0 clears the watchdog, 1 enters halt, other values dip the supply
  task automatic pulse(input int k);
    @(posedge ref_clk_in);
    case (k)
      0: clear_watchdog_in <= 1'b1;
      1: sleep_entry_in <= 1'b1;
      default: supply_dip_reset_in <= 1'b1;
    endcase
    @(posedge ref_clk_in);
    {clear_watchdog_in, sleep_entry_in, supply_dip_reset_in} <= 3'b000;
  endtask : pulse

  task automatic wait_cause(input logic [4:0] c);
    for (int i = 0; i < 400 && reset_cause_out !== c; i++) @(posedge ref_clk_in);
    #1;
    chk(16'(reset_cause_out), 16'(c));
  endtask : wait_cause

  task automatic load_all();
    for (int k = 4; k < 14; k++) reg_write(addr_t'(k), byte_t'(8'h40 + k));
    @(posedge ref_clk_in);
    pc_update_in <= 1'b1;
    pc_value_in <= 8'h33;
    sp_update_in <= 1'b1;
    sp_value_in <= 8'h03;
    @(posedge ref_clk_in);
    pc_update_in <= 1'b0;
    sp_update_in <= 1'b0;
  endtask : load_all

  // Mode 0 power-on, 1 active restart (working registers kept), 2 idle restart (all banked registers kept)
  task automatic check_bank(input int mode);
    byte_t e;
    for (int k = 4; k < 16; k++) begin
      e = (k == 6 || k == 7) ? 8'hff : (k == 15) ? 8'h07 : 8'h00;
      if (k < 14 && (mode == 2 || (mode == 1 && k >= 10))) e = byte_t'(8'h40 + k);
      reg_read(addr_t'(k), e);
    end
  endtask : check_bank

  task automatic flags(input logic [2:0] exp);
    chk(16'({timeout_flag_out, powerdown_flag_out, supply_dip_flag_out}), 16'(exp));
  endtask : flags

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    repeat (5000) @(posedge ref_clk_in);
    n_fail++;
    $display("BAD at %0t: run did not finish", $time);
    give_verdict();
  end

  initial begin
    {rst_in, supply_dip_reset_in, low_power_in, sleep_entry_in} = 4'b1000;
    {clear_watchdog_in, pc_update_in, sp_update_in, reg_wr_in, reg_rd_in} = 5'b00000;
    {pc_value_in, sp_value_in, reg_wdata_in, reg_addr_in} = 28'h0;
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    tick(4);
    chk(watchdog_counter_out, 16'h0004);
    chk({int_enable_out, timer_ctrl_out}, 16'h0000);
    chk({port_data_out, port_dir_out}, 16'hffff);
    chk({pullup_out, wakeup_out}, 16'h0000);
    chk({program_counter_low_out, stack_pointer_out}, 16'h0007);
    flags(3'b000);
    reg_read(4'h0, 8'h00);
    check_bank(0);
    $display("test power-on done");

    load_all();
    wait_cause(5'b01000);
    flags(3'b100);
    check_bank(1);
    reg_read(4'h0, 8'h20);
    $display("test active watchdog done");

    pulse(0);
    @(posedge ref_clk_in);
    low_power_in <= 1'b1;
    load_all();
    pulse(2);
    wait_cause(5'b10000);
    flags(3'b110);
    check_bank(2);
    $display("test idle watchdog done");

    @(posedge ref_clk_in);
    low_power_in <= 1'b0;
    pulse(1);
    tick(1);
    flags(3'b010);
    load_all();
    pulse(2);
    wait_cause(5'b00100);
    flags(3'b011);
    check_bank(1);
    reg_write(4'h1, 8'hff);
    reg_read(4'h1, 8'h04);
    reg_write(4'h1, 8'h00);
    reg_read(4'h1, 8'h00);
    $display("test supply dip done");

    pulse(0);
    reg_read(4'h2, 8'h07);
    for (int m = 1; m < 8; m = m * 4 + 1) begin
      reg_write(4'h3, byte_t'(m));
      tick(2);
      chk(16'(irq_out), 16'h0001);
      reg_write(4'h2, byte_t'(m));
      tick(2);
      chk(16'(irq_out), 16'h0000);
    end
    reg_read(4'h2, 8'h02);
    reg_write(4'h0, 8'hff);
    reg_write(4'he, 8'hff);
    reg_read(4'h0, 8'h00);
    reg_read(4'he, 8'h00);
    $display("test interrupts done");

    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    supply_dip_reset_in <= 1'b1;
    @(posedge ref_clk_in);
    supply_dip_reset_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    tick(6);
    chk(16'(reset_cause_out), 16'h0002);
    flags(3'b000);
    $display("test reset precedence done");
    give_verdict();
  end
endmodule : reset_initial_state_logic_tb
`default_nettype wire
